// File: sra_consts.svh
// Constants shared by both ends of the serial register access link
`ifndef SRA_CONSTS_SVH
`define SRA_CONSTS_SVH
`define SRA_ADDR_UPPER 6'h34
`define SRA_DIR_WRITE 1'b0
`define SRA_DIR_READ 1'b1
`define SRA_LAST_BIT 4'h7
`define SRA_ACK_BIT 4'h8
`define SRA_BIT_ZERO 4'h0
`define SRA_BIT_INC 4'h1
`define SRA_BIT_PRE 4'hf
`define SRA_SPI_LAST 3'h7
`define SRA_SPI_ZERO 3'h0
`define SRA_SPI_INC 3'h1
`define SRA_IDX_INC 8'h01
`define SRA_IDX7_INC 7'h01
`define SRA_BYTE_ZERO 8'h00
`define SRA_LEN_ONE 8'h01
`define SRA_SYNC_IDLE 3'h7
`define SRA_SYNC2_IDLE 2'h3
`define SRA_SYNC2_LOW 2'h0
`define SRA_IDX7_ZERO 7'h00
`define SRA_LINK_PERIOD_NS 160
`define SRA_SYS_PERIOD_NS 8
`define SRA_QTR_CYC ((`SRA_LINK_PERIOD_NS / `SRA_SYS_PERIOD_NS) / 4)
`define SRA_QTR_LAST 4'(`SRA_QTR_CYC - 1)
`define SRA_Q_ZERO 4'h0
`define SRA_Q_INC 4'h1
`define SRA_PH0 2'h0
`define SRA_PH1 2'h1
`define SRA_PH2 2'h2
`define SRA_PH3 2'h3
`define SRA_PH_INC 2'h1
`define SRA_STEP_ADDR_W 2'h0
`define SRA_STEP_INDEX 2'h1
`define SRA_STEP_ADDR_R 2'h2
`define SRA_STEP_DATA 2'h3
`endif

// File: sra_pkg.sv
// Types shared by both ends of the serial register access link
package sra_pkg;
	typedef enum logic [1:0] {D_IDLE, D_ADDR, D_RX, D_TX} dev_i2c_state_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_state_t;
endpackage

// File: sra_link_if.sv
// Pin level interface joining the master end and the register slave end
`timescale 1ns/100ps
`default_nettype none
interface sra_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic cs_n;
	logic dev_sdo_o;
	logic dev_sdo_oe;
	logic sda_line;
	logic sdo_line;

	// Data line resolves as a pulled-up wire; a released output reads high
	assign sda_line = ~((host_sda_oe & ~host_sda_o) | dev_sda_oe);
	assign sdo_line = dev_sdo_oe ? dev_sdo_o : 1'b1;

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		output cs_n,
		input sda_line,
		input sdo_line
	);
	modport device (
		input scl,
		input cs_n,
		input sda_line,
		output dev_sda_oe,
		output dev_sdo_o,
		output dev_sdo_oe
	);
endinterface
`default_nettype wire

// File: sra_host.sv
// Master end: drives I2C or SPI transfers to the register slave
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module sra_host (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	sra_link_if.host link,
	input wire logic spi_mode_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic start_i,
	input wire logic read_i,
	input wire logic [7:0] reg_idx_i,
	input wire logic [7:0] len_i,
	input wire logic [7:0] wdata_i,
	output logic wdata_take_o,
	output logic [7:0] rdata_o,
	output logic rdata_valid_o,
	output logic busy_o,
	output logic done_o,
	output logic nack_o
);
	sra_pkg::host_state_t state_ff;
	logic [3:0] q_ff, bit_ff;
	logic [1:0] ph_ff, step_ff;
	logic [7:0] tx_ff, rx_ff, left_ff, idx_ff;
	logic rd_ff, rx_mode_ff, scl_ff, sda_ff, cs_n_ff;
	logic take_ff, rvalid_ff, done_ff, nack_ff;
	logic [7:0] rdata_ff;
	logic [1:0] sda_sync_ff, sdo_sync_ff;
	logic tick, samp, last_bit;
	logic [7:0] rx_byte;

	// ----------------------------------------------------------------
	// Input synchronisers and quarter bit timing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sda_sync_ff <= `SRA_SYNC2_IDLE;
			sdo_sync_ff <= `SRA_SYNC2_IDLE;
		end else begin
			sda_sync_ff <= {sda_sync_ff[0], link.sda_line};
			sdo_sync_ff <= {sdo_sync_ff[0], link.sdo_line};
		end
	end

	// Quarter counter runs only while a transfer is active
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || state_ff == sra_pkg::H_IDLE) begin
			q_ff <= `SRA_Q_ZERO;
		end else begin
			q_ff <= tick ? `SRA_Q_ZERO : q_ff + `SRA_Q_INC;
		end
	end

	assign tick = (q_ff == `SRA_QTR_LAST);
	assign samp = spi_mode_i ? sdo_sync_ff[1] : sda_sync_ff[1];
	assign last_bit = spi_mode_i ? (bit_ff == `SRA_LAST_BIT) : (bit_ff == `SRA_ACK_BIT);
	assign rx_byte = spi_mode_i ? {rx_ff[6:0], samp} : rx_ff;

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_ff <= sra_pkg::H_IDLE;
			ph_ff <= `SRA_PH0;
			bit_ff <= `SRA_BIT_ZERO;
			step_ff <= `SRA_STEP_ADDR_W;
			tx_ff <= `SRA_BYTE_ZERO;
			rx_ff <= `SRA_BYTE_ZERO;
			left_ff <= `SRA_BYTE_ZERO;
			idx_ff <= `SRA_BYTE_ZERO;
			rdata_ff <= `SRA_BYTE_ZERO;
			rd_ff <= 1'b0;
			rx_mode_ff <= 1'b0;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			cs_n_ff <= 1'b1;
			take_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else begin
			take_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			done_ff <= 1'b0;
			case (state_ff)
			sra_pkg::H_IDLE: begin
				ph_ff <= `SRA_PH0;
				if (start_i) begin
					state_ff <= sra_pkg::H_START;
					step_ff <= `SRA_STEP_ADDR_W;
					rd_ff <= read_i;
					rx_mode_ff <= 1'b0;
					idx_ff <= reg_idx_i;
					nack_ff <= 1'b0;
					left_ff <= (len_i == `SRA_BYTE_ZERO) ? `SRA_LEN_ONE : len_i;
					tx_ff <= spi_mode_i ? {read_i, reg_idx_i[6:0]} : {dev_addr_i, `SRA_DIR_WRITE};
				end
			end
			sra_pkg::H_START: if (tick) begin
				ph_ff <= ph_ff + `SRA_PH_INC;
				// Repeated start may begin with the clock high, so lower it first
				case (ph_ff)
				`SRA_PH0: begin
					if (spi_mode_i) cs_n_ff <= 1'b0;
					else scl_ff <= 1'b0;
				end
				`SRA_PH1: if (!spi_mode_i) sda_ff <= 1'b1;
				`SRA_PH2: if (!spi_mode_i) scl_ff <= 1'b1;
				default: begin
					if (!spi_mode_i) sda_ff <= 1'b0;
					state_ff <= sra_pkg::H_BYTE;
					bit_ff <= `SRA_BIT_ZERO;
				end
				endcase
			end
			sra_pkg::H_BYTE: if (tick) begin
				ph_ff <= ph_ff + `SRA_PH_INC;
				case (ph_ff)
				`SRA_PH0: scl_ff <= 1'b0;
				`SRA_PH1: begin
					// Data changes a full quarter after the clock fell
					if (bit_ff == `SRA_ACK_BIT) sda_ff <= rx_mode_ff ? (left_ff == `SRA_LEN_ONE) : 1'b1;
					else sda_ff <= rx_mode_ff ? 1'b1 : tx_ff[7];
				end
				`SRA_PH2: scl_ff <= 1'b1;
				default: begin
					if (bit_ff != `SRA_ACK_BIT) rx_ff <= {rx_ff[6:0], samp};
					tx_ff <= {tx_ff[6:0], 1'b0};
					bit_ff <= last_bit ? `SRA_BIT_ZERO : bit_ff + `SRA_BIT_INC;
					if (last_bit) begin
						if (!spi_mode_i && !rx_mode_ff && samp) begin
							nack_ff <= 1'b1;
							state_ff <= sra_pkg::H_STOP;
						end else if (rx_mode_ff) begin
							rdata_ff <= rx_byte;
							rvalid_ff <= 1'b1;
							left_ff <= left_ff - `SRA_LEN_ONE;
							if (left_ff == `SRA_LEN_ONE) state_ff <= sra_pkg::H_STOP;
						end else begin
							case (step_ff)
							`SRA_STEP_ADDR_W: begin
								if (spi_mode_i) begin
									step_ff <= `SRA_STEP_DATA;
									rx_mode_ff <= rd_ff;
									tx_ff <= rd_ff ? `SRA_BYTE_ZERO : wdata_i;
									take_ff <= ~rd_ff;
								end else begin
									step_ff <= `SRA_STEP_INDEX;
									tx_ff <= idx_ff;
								end
							end
							`SRA_STEP_INDEX: begin
								if (rd_ff) begin
									state_ff <= sra_pkg::H_START;
									step_ff <= `SRA_STEP_ADDR_R;
									tx_ff <= {dev_addr_i, `SRA_DIR_READ};
								end else begin
									step_ff <= `SRA_STEP_DATA;
									tx_ff <= wdata_i;
									take_ff <= 1'b1;
								end
							end
							`SRA_STEP_ADDR_R: begin
								step_ff <= `SRA_STEP_DATA;
								rx_mode_ff <= 1'b1;
							end
							default: begin
								left_ff <= left_ff - `SRA_LEN_ONE;
								if (left_ff == `SRA_LEN_ONE) begin
									state_ff <= sra_pkg::H_STOP;
								end else begin
									tx_ff <= wdata_i;
									take_ff <= 1'b1;
								end
							end
							endcase
						end
					end
				end
				endcase
			end
			default: if (tick) begin
				ph_ff <= ph_ff + `SRA_PH_INC;
				// SPI ends by chip select alone; the clock stays idle high
				case (ph_ff)
				`SRA_PH0: if (!spi_mode_i) scl_ff <= 1'b0;
				`SRA_PH1: if (!spi_mode_i) sda_ff <= 1'b0;
				`SRA_PH2: if (!spi_mode_i) scl_ff <= 1'b1;
				default: begin
					sda_ff <= 1'b1;
					cs_n_ff <= 1'b1;
					state_ff <= sra_pkg::H_IDLE;
					done_ff <= 1'b1;
				end
				endcase
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin and user outputs
	// ----------------------------------------------------------------
	assign link.scl = scl_ff;
	assign link.host_sda_o = spi_mode_i ? sda_ff : 1'b0;
	assign link.host_sda_oe = spi_mode_i ? ~cs_n_ff : ~sda_ff;
	assign link.cs_n = cs_n_ff;
	assign wdata_take_o = take_ff;
	assign rdata_o = rdata_ff;
	assign rdata_valid_o = rvalid_ff;
	assign busy_o = (state_ff != sra_pkg::H_IDLE);
	assign done_o = done_ff;
	assign nack_o = nack_ff;
endmodule
`default_nettype wire

// File: sra_device.sv
// Register slave end: I2C and SPI access to an external register store
// Contract
// - Master sends 7-bit address then direction
// - Direction bit 0 writes, 1 reads
// - Master releases data for acknowledge
// - Slave holds data low in ninth clock
// - STOP ends transfer; repeated START allowed
// - Data changes only while clock low
// - Write: address, index, data, each acknowledged
// - Further write bytes go to next index
// - Read: write index, restart, read address
// - Master ends read with NACK, STOP
// - Master ACK requests another data byte
// - SPI slave selected by active-low select
// - SPI output released while select high
// - SPI bytes travel most significant first
// - SPI receiver samples on rising edge
// - SPI transmitter changes on falling edge
// - SPI frame: address byte plus data
// - SPI first bit read flag, index follows
// - SPI single and burst transfers supported
// - Address upper six fixed, low bit strapped
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module sra_device (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	sra_link_if.device link,
	input wire logic spi_mode_i,
	input wire logic address_select_pin_i,
	output logic [7:0] reg_idx_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i
);
	logic [2:0] scl_sync_ff, sda_sync_ff, cs_sync_ff;
	logic [1:0] sel_sync_ff;
	logic scl_rise, scl_fall, sda_rise, sda_fall, sda_bit, sel_bit;
	logic i2c_start, i2c_stop, spi_sel;
	logic [6:0] own_addr;

	sra_pkg::dev_i2c_state_t i2c_state_ff;
	logic [3:0] i2c_cnt_ff;
	logic [7:0] i2c_sh_ff, i2c_idx_ff, i2c_wdata_ff;
	logic i2c_rw_ff, i2c_first_ff, i2c_nack_ff, i2c_oe_ff, i2c_wr_ff, i2c_rd_ff;

	logic [2:0] spi_cnt_ff;
	logic [7:0] spi_sh_ff, spi_tx_ff, spi_wdata_ff;
	logic [6:0] spi_idx_ff;
	logic spi_addr_done_ff, spi_rw_ff, spi_sdo_ff, spi_wr_ff, spi_rd_ff;

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	// Stage 0 feeds only stage 1; edges compare stages 1 and 2
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			scl_sync_ff <= `SRA_SYNC_IDLE;
			sda_sync_ff <= `SRA_SYNC_IDLE;
			cs_sync_ff <= `SRA_SYNC_IDLE;
			sel_sync_ff <= `SRA_SYNC2_LOW;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], link.scl};
			sda_sync_ff <= {sda_sync_ff[1:0], link.sda_line};
			cs_sync_ff <= {cs_sync_ff[1:0], link.cs_n};
			sel_sync_ff <= {sel_sync_ff[0], address_select_pin_i};
		end
	end

	assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
	assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
	assign sda_rise = sda_sync_ff[1] & ~sda_sync_ff[2];
	assign sda_fall = ~sda_sync_ff[1] & sda_sync_ff[2];
	assign sda_bit = sda_sync_ff[1];
	assign sel_bit = sel_sync_ff[1];
	// Data moving while the clock stays high marks frame boundaries
	assign i2c_start = ~spi_mode_i & scl_sync_ff[1] & scl_sync_ff[2] & sda_fall;
	assign i2c_stop = ~spi_mode_i & scl_sync_ff[1] & scl_sync_ff[2] & sda_rise;
	assign own_addr = {`SRA_ADDR_UPPER, sel_bit};
	assign spi_sel = spi_mode_i & ~cs_sync_ff[1];

	// ----------------------------------------------------------------
	// I2C byte engine
	// ----------------------------------------------------------------
	// Counter tracks clock falls in a byte: 0..7 data, 8 acknowledge
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			i2c_state_ff <= sra_pkg::D_IDLE;
			i2c_cnt_ff <= `SRA_BIT_ZERO;
			i2c_sh_ff <= `SRA_BYTE_ZERO;
			i2c_idx_ff <= `SRA_BYTE_ZERO;
			i2c_wdata_ff <= `SRA_BYTE_ZERO;
			i2c_rw_ff <= `SRA_DIR_WRITE;
			i2c_first_ff <= 1'b0;
			i2c_nack_ff <= 1'b0;
			i2c_oe_ff <= 1'b0;
			i2c_wr_ff <= 1'b0;
			i2c_rd_ff <= 1'b0;
		end else begin
			i2c_wr_ff <= 1'b0;
			i2c_rd_ff <= 1'b0;
			if (i2c_wr_ff || i2c_rd_ff) i2c_idx_ff <= i2c_idx_ff + `SRA_IDX_INC;
			if (spi_mode_i || i2c_stop) begin
				i2c_state_ff <= sra_pkg::D_IDLE;
				i2c_oe_ff <= 1'b0;
			end else if (i2c_start) begin
				// The clock falls once more before bit 0, so start one below zero
				i2c_state_ff <= sra_pkg::D_ADDR;
				i2c_cnt_ff <= `SRA_BIT_PRE;
				i2c_oe_ff <= 1'b0;
			end else if (i2c_state_ff != sra_pkg::D_IDLE) begin
				if (scl_rise) begin
					if (i2c_cnt_ff != `SRA_ACK_BIT && i2c_state_ff != sra_pkg::D_TX) begin
						i2c_sh_ff <= {i2c_sh_ff[6:0], sda_bit};
					end
					if (i2c_cnt_ff == `SRA_ACK_BIT && i2c_state_ff == sra_pkg::D_TX) begin
						i2c_nack_ff <= sda_bit;
					end
				end
				if (scl_fall) begin
					if (i2c_cnt_ff == `SRA_LAST_BIT) begin
						i2c_cnt_ff <= `SRA_ACK_BIT;
						case (i2c_state_ff)
						sra_pkg::D_ADDR: begin
							if (i2c_sh_ff[7:1] == own_addr) begin
								i2c_oe_ff <= 1'b1;
								i2c_rw_ff <= i2c_sh_ff[0];
								i2c_first_ff <= 1'b1;
							end else begin
								i2c_state_ff <= sra_pkg::D_IDLE;
							end
						end
						sra_pkg::D_RX: begin
							i2c_oe_ff <= 1'b1;
							i2c_first_ff <= 1'b0;
							if (i2c_first_ff) begin
								i2c_idx_ff <= i2c_sh_ff;
							end else begin
								i2c_wr_ff <= 1'b1;
								i2c_wdata_ff <= i2c_sh_ff;
							end
						end
						default: i2c_oe_ff <= 1'b0;
						endcase
					end else if (i2c_cnt_ff == `SRA_ACK_BIT) begin
						// Acknowledge ends; a read starts or continues here
						i2c_cnt_ff <= `SRA_BIT_ZERO;
						i2c_oe_ff <= 1'b0;
						if (i2c_state_ff == sra_pkg::D_ADDR) begin
							i2c_state_ff <= (i2c_rw_ff == `SRA_DIR_READ) ? sra_pkg::D_TX : sra_pkg::D_RX;
						end
						if ((i2c_state_ff == sra_pkg::D_ADDR && i2c_rw_ff == `SRA_DIR_READ) ||
							(i2c_state_ff == sra_pkg::D_TX && !i2c_nack_ff)) begin
							i2c_sh_ff <= reg_rdata_i;
							i2c_rd_ff <= 1'b1;
							i2c_oe_ff <= ~reg_rdata_i[7];
						end else if (i2c_state_ff == sra_pkg::D_TX) begin
							i2c_state_ff <= sra_pkg::D_IDLE;
						end
					end else begin
						i2c_cnt_ff <= i2c_cnt_ff + `SRA_BIT_INC;
						if (i2c_state_ff == sra_pkg::D_TX) begin
							i2c_sh_ff <= {i2c_sh_ff[6:0], 1'b0};
							i2c_oe_ff <= ~i2c_sh_ff[6];
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// SPI byte engine
	// ----------------------------------------------------------------
	// Counter wraps every eight rising edges while selected
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			spi_cnt_ff <= `SRA_SPI_ZERO;
			spi_sh_ff <= `SRA_BYTE_ZERO;
			spi_tx_ff <= `SRA_BYTE_ZERO;
			spi_wdata_ff <= `SRA_BYTE_ZERO;
			spi_idx_ff <= `SRA_IDX7_ZERO;
			spi_addr_done_ff <= 1'b0;
			spi_rw_ff <= `SRA_DIR_WRITE;
			spi_sdo_ff <= 1'b1;
			spi_wr_ff <= 1'b0;
			spi_rd_ff <= 1'b0;
		end else begin
			spi_wr_ff <= 1'b0;
			spi_rd_ff <= 1'b0;
			if (spi_wr_ff || spi_rd_ff) spi_idx_ff <= spi_idx_ff + `SRA_IDX7_INC;
			if (!spi_sel) begin
				spi_cnt_ff <= `SRA_SPI_ZERO;
				spi_addr_done_ff <= 1'b0;
			end else begin
				if (scl_rise) begin
					spi_cnt_ff <= spi_cnt_ff + `SRA_SPI_INC;
					spi_sh_ff <= {spi_sh_ff[6:0], sda_bit};
					if (spi_cnt_ff == `SRA_SPI_LAST) begin
						if (!spi_addr_done_ff) begin
							spi_addr_done_ff <= 1'b1;
							spi_rw_ff <= spi_sh_ff[6];
							spi_idx_ff <= {spi_sh_ff[5:0], sda_bit};
						end else if (spi_rw_ff == `SRA_DIR_WRITE) begin
							spi_wr_ff <= 1'b1;
							spi_wdata_ff <= {spi_sh_ff[6:0], sda_bit};
						end
					end
				end
				// The leading fall before the first rise is ignored, address not done
				if (scl_fall && spi_addr_done_ff && spi_rw_ff == `SRA_DIR_READ) begin
					if (spi_cnt_ff == `SRA_SPI_ZERO) begin
						spi_tx_ff <= reg_rdata_i;
						spi_rd_ff <= 1'b1;
						spi_sdo_ff <= reg_rdata_i[7];
					end else begin
						spi_tx_ff <= {spi_tx_ff[6:0], 1'b0};
						spi_sdo_ff <= spi_tx_ff[6];
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only one engine is live at a time, chosen by the mode input
	assign link.dev_sda_oe = i2c_oe_ff;
	assign link.dev_sdo_o = spi_sdo_ff;
	assign link.dev_sdo_oe = spi_sel;
	assign reg_idx_o = spi_mode_i ? {1'b0, spi_idx_ff} : i2c_idx_ff;
	assign reg_wr_o = spi_mode_i ? spi_wr_ff : i2c_wr_ff;
	assign reg_wdata_o = spi_mode_i ? spi_wdata_ff : i2c_wdata_ff;
	assign reg_rd_o = spi_mode_i ? spi_rd_ff : i2c_rd_ff;
endmodule
`default_nettype wire

// File: sra_link_sva.sv
// Assertions on the pins joining the master end and the register slave end
`timescale 1ns/100ps
`default_nettype none
module sra_link_sva (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic spi_mode_i,
	input wire logic scl,
	input wire logic cs_n,
	input wire logic dev_sda_oe,
	input wire logic dev_sdo_o,
	input wire logic dev_sdo_oe,
	input wire logic sda_line
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// ----------------------------------------
	// Slave pin rules
	// ----------------------------------------
	// Select is synced, so allow its delay before the output must let go
	property p_sdo_hiz;
		cs_n [*5] |-> !dev_sdo_oe;
	endproperty
	a_sdo_hiz: assert property (p_sdo_hiz) else $error("sdo driven while deselected");
	property p_i2c_sdo_off;
		!spi_mode_i |-> !dev_sdo_oe;
	endproperty
	a_i2c_sdo_off: assert property (p_i2c_sdo_off) else $error("sdo driven in i2c mode");
	property p_spi_sda_off;
		spi_mode_i |-> !dev_sda_oe;
	endproperty
	a_spi_sda_off: assert property (p_spi_sda_off) else $error("sda pulled in spi mode");
	// Slave never moves the data line while the clock is high
	property p_sda_stable_high;
		!spi_mode_i && scl && $past(scl) |-> $stable(dev_sda_oe);
	endproperty
	a_sda_stable_high: assert property (p_sda_stable_high) else $error("sda moved, scl high");
	// A low driven bit or ack lasts far longer than a few cycles
	property p_ack_hold;
		!spi_mode_i && $rose(dev_sda_oe) |-> dev_sda_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda low pulse too short");
	property p_sdo_stable_high;
		spi_mode_i && scl && $past(scl) && dev_sdo_oe && $past(dev_sdo_oe) |-> $stable(dev_sdo_o);
	endproperty
	a_sdo_stable_high: assert property (p_sdo_stable_high) else $error("sdo moved, clk high");
	// A change must follow a falling clock by the sync delay only
	property p_sdo_change_fall;
		spi_mode_i && dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo_o)
			|-> !scl && $past(scl, 5);
	endproperty
	a_sdo_change_fall: assert property (p_sdo_change_fall) else $error("sdo not after fall");
	// ----------------------------------------
	// Master pin rules
	// ----------------------------------------
	// Mode 3: select moves only while the clock idles high
	property p_cs_scl_high;
		$changed(cs_n) |-> scl;
	endproperty
	a_cs_scl_high: assert property (p_cs_scl_high) else $error("select moved, clk low");
	c_ack: cover property (!spi_mode_i && $rose(dev_sda_oe));
	c_start: cover property (!spi_mode_i && scl && $fell(sda_line));
	c_spi_out: cover property (spi_mode_i && !cs_n && dev_sdo_oe);
endmodule
`default_nettype wire

// File: serial_register_access_slave_bench.sv
// Bench joining both link ends with a register store on the slave side
`timescale 1ns/100ps
`default_nettype none
module serial_register_access_slave_bench;
	logic clk_sys_i, resetn_i, spi_mode_i, address_select_pin_i, start_i, read_i;
	logic [6:0] dev_addr_i;
	logic [7:0] reg_idx_i, len_i, wdata_i, wbase, wcnt, rdata, reg_idx, reg_wdata, reg_rdata;
	logic wdata_take, rdata_valid, busy, done, nack, reg_wr, reg_rd;
	logic [7:0] regs [0:255];
	logic [7:0] rq [$];
	int n_mismatch, tests_run, wr_count, rd_count;

	sra_link_if link_bus ();
	sra_host u_sra_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link_bus),
		.spi_mode_i(spi_mode_i), .dev_addr_i(dev_addr_i), .start_i(start_i), .read_i(read_i),
		.reg_idx_i(reg_idx_i), .len_i(len_i), .wdata_i(wdata_i), .wdata_take_o(wdata_take),
		.rdata_o(rdata), .rdata_valid_o(rdata_valid), .busy_o(busy), .done_o(done),
		.nack_o(nack));
	sra_device u_sra_device (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link_bus),
		.spi_mode_i(spi_mode_i), .address_select_pin_i(address_select_pin_i),
		.reg_idx_o(reg_idx), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd),
		.reg_rdata_i(reg_rdata));
	sra_link_sva u_sra_link_sva (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.spi_mode_i(spi_mode_i), .scl(link_bus.scl), .cs_n(link_bus.cs_n),
		.dev_sda_oe(link_bus.dev_sda_oe), .dev_sdo_o(link_bus.dev_sdo_o),
		.dev_sdo_oe(link_bus.dev_sdo_oe), .sda_line(link_bus.sda_line));

	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Register store; reads see the indexed entry at once, as the slave expects
	assign reg_rdata = regs[reg_idx];
	assign wdata_i = wbase + wcnt;
	always @(posedge clk_sys_i) begin
		if (reg_wr) begin
			regs[reg_idx] <= reg_wdata;
			wr_count <= wr_count + 1;
		end
		if (reg_rd) rd_count <= rd_count + 1;
		if (rdata_valid) rq.push_back(rdata);
		if (wdata_take) wcnt <= wcnt + 8'h01;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (exp !== got) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One whole frame; the wait is bounded so a stuck master ends the run
	task automatic xfer(input logic spi, input logic [6:0] addr, input logic rd,
		input logic [7:0] idx, input logic [7:0] len);
		int i;
		@(posedge clk_sys_i);
		spi_mode_i <= spi;
		dev_addr_i <= addr;
		read_i <= rd;
		reg_idx_i <= idx;
		len_i <= len;
		wcnt <= 8'h00;
		rq.delete();
		repeat (4) @(posedge clk_sys_i);
		start_i <= 1'b1;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		#1;
		check("busy at start", 8'h01, {7'h00, busy});
		for (i = 0; i < 8000 && done !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (i == 8000) begin
			n_mismatch++;
			$display("ERROR xfer done expected 1 seen 0");
			summarize();
		end
		check("busy at done", 8'h00, {7'h00, busy});
		repeat (10) @(posedge clk_sys_i);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic i2c_write_burst();
		int w0;
		w0 = wr_count;
		wbase <= 8'h5c;
		xfer(1'b0, 7'h68, 1'b0, 8'h10, 8'h03);
		check("i2c write count", 8'h03, 8'(wr_count - w0));
		check("i2c write nack", 8'h00, {7'h00, nack});
		for (int k = 0; k < 3; k++) check("i2c wdata", 8'h5c + 8'(k), regs[8'h10 + 8'(k)]);
	endtask

	// Burst then single read; the last byte is refused by the master
	task automatic i2c_reads();
		int r0;
		r0 = rd_count;
		xfer(1'b0, 7'h68, 1'b1, 8'h10, 8'h03);
		check("i2c burst count", 8'h03, 8'(rq.size()));
		check("i2c burst fetches", 8'h03, 8'(rd_count - r0));
		for (int k = 0; k < 3; k++) check("i2c rdata", 8'h5c + 8'(k), rq[k]);
		xfer(1'b0, 7'h68, 1'b1, 8'h40, 8'h01);
		check("i2c single count", 8'h01, 8'(rq.size()));
		check("i2c single data", 8'he0, rq[0]);
		check("i2c total fetches", 8'h04, 8'(rd_count - r0));
	endtask

	// Low address bit follows the strap; a foreign address is not answered
	task automatic i2c_addr_select();
		int w0;
		w0 = wr_count;
		wbase <= 8'h33;
		xfer(1'b0, 7'h69, 1'b0, 8'h50, 8'h01);
		check("foreign nack", 8'h01, {7'h00, nack});
		check("foreign writes", 8'h00, 8'(wr_count - w0));
		address_select_pin_i <= 1'b1;
		xfer(1'b0, 7'h69, 1'b0, 8'h50, 8'h01);
		check("strap nack", 8'h00, {7'h00, nack});
		check("strap data", 8'h33, regs[8'h50]);
	endtask

	task automatic spi_transfers();
		int w0;
		int r0;
		logic [7:0] exp [4];
		exp = '{8'hbf, 8'hc1, 8'hc2, 8'h82};
		w0 = wr_count;
		r0 = rd_count;
		wbase <= 8'hc1;
		xfer(1'b1, 7'h00, 1'b0, 8'h20, 8'h02);
		check("spi write count", 8'h02, 8'(wr_count - w0));
		check("spi wdata", 8'hc2, regs[8'h21]);
		xfer(1'b1, 7'h00, 1'b1, 8'h1f, 8'h04);
		check("spi read count", 8'h04, 8'(rq.size()));
		check("spi fetches", 8'h04, 8'(rd_count - r0));
		for (int k = 0; k < 4; k++) check("spi rdata", exp[k], rq[k]);
		wbase <= 8'h9e;
		xfer(1'b1, 7'h00, 1'b0, 8'h7f, 8'h00);
		check("spi top index", 8'h9e, regs[8'h7f]);
		check("spi total writes", 8'h03, 8'(wr_count - w0));
		check("spi select idle", 8'h01, {7'h00, link_bus.cs_n});
	endtask

	initial begin
		resetn_i = 1'b0;
		spi_mode_i = 1'b0;
		address_select_pin_i = 1'b0;
		start_i = 1'b0;
		read_i = 1'b0;
		dev_addr_i = 7'h00;
		reg_idx_i = 8'h00;
		len_i = 8'h01;
		wbase = 8'h00;
		wcnt = 8'h00;
		for (int k = 0; k < 256; k++) regs[k] = 8'ha0 ^ 8'(k);
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		i2c_write_burst();
		i2c_reads();
		i2c_addr_select();
		spi_transfers();
		summarize();
	end
endmodule
`default_nettype wire
